// ==== rtl/hvps_sequencer.sv ====
/*
  HV contactor pre-charge sequencer with AHB-Lite register slave.
  Assumes pin inputs are asynchronous and bus/pack voltages come from
  logic on the system clock.
*/
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module hvps_sequencer
  import hvps_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
)(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_wake,
  input wire logic i_ignition,
  input wire logic i_neg_feedback_raw,
  input wire logic i_inverter_fault,
  input wire logic i_insulation_fault,
  input wire logic i_interlock_loop_ok,
  input wire logic i_charge_plug_present,
  input wire logic [15:0] i_bus_voltage,
  input wire logic [15:0] i_pack_voltage,
  output logic o_neg_close,
  output logic o_pre_close,
  output logic o_pos_close,
  output logic o_pdu_neg_close,
  output logic o_pdu_pre_close,
  output logic o_pdu_pos_close,
  output logic o_preconditions_met,
  output logic o_neg_feedback_state,
  output logic o_rate_condition_met,
  output logic o_no_hv_flag,
  output logic o_partial_hv_flag,
  output logic o_full_hv_flag,
  output logic o_precharge_done_flag,
  output logic o_precharge_fault
);
  typedef struct packed {
    logic [4:0] ctrl;
    logic [15:0] partial_thr;
    logic [15:0] full_thr;
    logic [15:0] delta_lim;
    logic [15:0] no_hv_thr;
    logic [15:0] rate_on;
    logic [15:0] rate_off;
    logic [15:0] neg_dly;
    logic [15:0] hold;
    logic [15:0] fault_to;
    logic [15:0] retry_min;
    logic [15:0] retry_wait;
    logic [3:0] max_att;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [31:0] tick_cnt;
    hvps_state_t st;
    logic [15:0] timer;
    logic [3:0] attempts;
    logic partial_seen;
    logic fault;
    logic done;
    logic neg;
    logic pre;
    logic pos;
    logic pdu_neg;
    logic pdu_pre;
    logic pdu_pos;
    logic precond;
    logic fb_state;
    logic no_hv;
    logic partial;
    logic full;
  } hvps_top_t;

  hvps_top_t q;
  hvps_top_t d;
  logic [6:0] pins_s;
  logic wake_s;
  logic ign_s;
  logic fb_s;
  logic precond_now;
  logic fb_now;
  logic rate_met;
  logic tick;
  logic tmr_zero;
  logic complete;
  logic fail;
  logic accept;
  logic [31:0] rd_word;

  hvps_sync #(
    .W(7)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_async({i_wake, i_ignition, i_neg_feedback_raw, i_inverter_fault,
              i_insulation_fault, i_interlock_loop_ok, i_charge_plug_present}),
    .o_sync(pins_s)
  );

  hvps_rate_det u_rate (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_tick(tick),
    .i_voltage(i_bus_voltage),
    .i_rate_on(q.rate_on),
    .i_rate_off(q.rate_off),
    .o_rate_met(rate_met)
  );

  assign wake_s = pins_s[6];
  assign ign_s = pins_s[5];
  assign fb_s = pins_s[4];
  assign precond_now = !pins_s[3] && !pins_s[2] && pins_s[1] && !pins_s[0];
  // Default polarity: a grounded input means closed
  assign fb_now = q.ctrl[CTRL_FB_POL] ? fb_s : !fb_s;
  assign accept = i_hsel && i_htrans[1] && i_hready;
  assign tick = (q.tick_cnt == 32'(P_TICK_CYCLES - 1));
  assign tmr_zero = (q.timer == 16'h0000);
  // Rate mode also needs partial voltage so an idle bus never looks settled
  assign complete = q.ctrl[CTRL_SRC_PACK] ? q.full : (rate_met && q.partial);
  assign fail = (q.st == ST_PRECHG) && tmr_zero && !complete;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (i_haddr[7:0])
      ADDR_CTRL: rd_word = 32'(q.ctrl);
      ADDR_PARTIAL_THR: rd_word = 32'(q.partial_thr);
      ADDR_FULL_THR: rd_word = 32'(q.full_thr);
      ADDR_DELTA_LIMIT: rd_word = 32'(q.delta_lim);
      ADDR_NO_HV_THR: rd_word = 32'(q.no_hv_thr);
      ADDR_RATE_ON: rd_word = 32'(q.rate_on);
      ADDR_RATE_OFF: rd_word = 32'(q.rate_off);
      ADDR_NEG_DELAY: rd_word = 32'(q.neg_dly);
      ADDR_SETTLE_HOLD: rd_word = 32'(q.hold);
      ADDR_FAULT_TIMEOUT: rd_word = 32'(q.fault_to);
      ADDR_RETRY_MIN: rd_word = 32'(q.retry_min);
      ADDR_RETRY_WAIT: rd_word = 32'(q.retry_wait);
      ADDR_MAX_ATTEMPTS: rd_word = 32'(q.max_att);
      ADDR_STATUS:
      begin
        rd_word[7:0] = {q.fault, q.done, q.full, q.partial, q.no_hv, rate_met,
                        q.fb_state, q.precond};
        rd_word[STAT_STATE_LSB +: 3] = q.st;
        rd_word[STAT_ATT_LSB +: 4] = q.attempts;
      end
      default: rd_word = 32'h0000_0000;
    endcase
    if (i_haddr[31:8] != 24'h00_0000)
      rd_word = 32'h0000_0000;
  end

  always_comb
  begin
    d = q;
    d.hreadyout = 1'b1;
    d.wr_pend = accept && i_hwrite && (i_haddr[31:8] == 24'h00_0000);
    d.wr_addr = i_haddr[7:0];
    d.hrdata = (accept && !i_hwrite) ? rd_word : 32'h0000_0000;
    if (q.wr_pend)
    begin
      case (q.wr_addr)
        ADDR_CTRL: d.ctrl = i_hwdata[4:0];
        ADDR_PARTIAL_THR: d.partial_thr = i_hwdata[15:0];
        ADDR_FULL_THR: d.full_thr = i_hwdata[15:0];
        ADDR_DELTA_LIMIT: d.delta_lim = i_hwdata[15:0];
        ADDR_NO_HV_THR: d.no_hv_thr = i_hwdata[15:0];
        ADDR_RATE_ON: d.rate_on = i_hwdata[15:0];
        ADDR_RATE_OFF: d.rate_off = i_hwdata[15:0];
        ADDR_NEG_DELAY: d.neg_dly = i_hwdata[15:0];
        ADDR_SETTLE_HOLD: d.hold = i_hwdata[15:0];
        ADDR_FAULT_TIMEOUT: d.fault_to = i_hwdata[15:0];
        ADDR_RETRY_MIN: d.retry_min = i_hwdata[15:0];
        ADDR_RETRY_WAIT: d.retry_wait = i_hwdata[15:0];
        ADDR_MAX_ATTEMPTS: d.max_att = i_hwdata[3:0];
        default: d.ctrl = q.ctrl;
      endcase
    end

    d.tick_cnt = tick ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;
    if (tick && !tmr_zero)
      d.timer = q.timer - 16'h0001;

    d.precond = precond_now;
    d.fb_state = fb_now;
    d.partial = i_bus_voltage > q.partial_thr;
    d.full = (i_bus_voltage > q.full_thr) &&
             (abs_diff(i_pack_voltage, i_bus_voltage) <= q.delta_lim);
    d.no_hv = q.ctrl[CTRL_SRC_PACK] && (i_bus_voltage < q.no_hv_thr);

    // Timer loads restart the tick so every wait is whole ticks long
    case (q.st)
      ST_IDLE:
      begin
        d.attempts = 4'h0;
        d.partial_seen = 1'b0;
        d.done = 1'b0;
        if (precond_now && !q.fault && q.max_att != 4'h0)
        begin
          d.st = ST_NEG_WAIT;
          d.attempts = 4'h1;
        end
      end
      ST_NEG_WAIT:
      begin
        if (!q.ctrl[CTRL_FB_REQ] || fb_now)
        begin
          d.st = ST_DELAY;
          d.timer = q.neg_dly;
          d.tick_cnt = 32'h0000_0000;
        end
      end
      ST_DELAY:
      begin
        if (tmr_zero)
        begin
          d.st = ST_PRECHG;
          d.timer = q.fault_to;
          d.tick_cnt = 32'h0000_0000;
        end
      end
      ST_PRECHG:
      begin
        if (q.partial)
          d.partial_seen = 1'b1;
        if (complete)
        begin
          d.st = ST_SETTLE;
          d.timer = q.hold;
          d.tick_cnt = 32'h0000_0000;
        end
        else if (fail && q.partial_seen && q.attempts < q.max_att)
        begin
          d.st = ST_RETRY;
          d.timer = (q.attempts == 4'h1) ? q.retry_min : q.retry_wait;
          d.tick_cnt = 32'h0000_0000;
        end
        else if (fail)
        begin
          d.st = ST_FAULT;
          d.fault = 1'b1;
        end
      end
      ST_RETRY:
      begin
        if (tmr_zero)
        begin
          d.st = ST_NEG_WAIT;
          d.attempts = q.attempts + 4'h1;
          d.partial_seen = 1'b0;
        end
      end
      ST_SETTLE:
      begin
        if (tmr_zero)
        begin
          d.st = ST_DONE;
          d.done = 1'b1;
        end
      end
      ST_DONE: d.st = ST_DONE;
      ST_FAULT: d.st = ST_FAULT;
      default: d.st = ST_IDLE;
    endcase

    // Fault latches until ignition goes off or bypass is set
    if (!ign_s || q.ctrl[CTRL_BYPASS])
    begin
      d.st = ST_IDLE;
      d.fault = 1'b0;
      d.done = 1'b0;
    end
    else if (!precond_now && q.st != ST_FAULT)
    begin
      d.st = ST_IDLE;
      d.done = 1'b0;
    end

    if (q.ctrl[CTRL_NEG_MODE])
      d.neg = (d.st != ST_IDLE) && (d.st != ST_FAULT);
    else
      d.neg = wake_s && precond_now;
    d.pre = (d.st == ST_PRECHG) || (d.st == ST_SETTLE);
    d.pos = (d.st == ST_SETTLE) || (d.st == ST_DONE);
    d.pdu_neg = d.neg;
    d.pdu_pre = d.pre;
    d.pdu_pos = d.pos;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      q <= '0;
      q.ctrl <= RST_CTRL;
      q.partial_thr <= RST_PARTIAL_THR;
      q.full_thr <= RST_FULL_THR;
      q.delta_lim <= RST_DELTA_LIMIT;
      q.no_hv_thr <= RST_NO_HV_THR;
      q.rate_on <= RST_RATE_ON;
      q.rate_off <= RST_RATE_OFF;
      q.neg_dly <= RST_NEG_DELAY;
      q.hold <= RST_SETTLE_HOLD;
      q.fault_to <= RST_FAULT_TIMEOUT;
      q.retry_min <= RST_RETRY_MIN;
      q.retry_wait <= RST_RETRY_WAIT;
      q.max_att <= RST_MAX_ATTEMPTS;
      q.st <= ST_IDLE;
    end
    else
      q <= d;
  end

  assign o_hrdata = q.hrdata;
  assign o_hreadyout = q.hreadyout;
  assign o_hresp = 1'b0;
  assign o_neg_close = q.neg;
  assign o_pre_close = q.pre;
  assign o_pos_close = q.pos;
  assign o_pdu_neg_close = q.pdu_neg;
  assign o_pdu_pre_close = q.pdu_pre;
  assign o_pdu_pos_close = q.pdu_pos;
  assign o_preconditions_met = q.precond;
  assign o_neg_feedback_state = q.fb_state;
  assign o_rate_condition_met = rate_met;
  assign o_no_hv_flag = q.no_hv;
  assign o_partial_hv_flag = q.partial;
  assign o_full_hv_flag = q.full;
  assign o_precharge_done_flag = q.done;
  assign o_precharge_fault = q.fault;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  property p_fb_gate;
    (q.st == ST_NEG_WAIT) && q.ctrl[CTRL_FB_REQ] && !fb_now |=> q.st != ST_DELAY;
  endproperty
  a_fb_gate: assert property (p_fb_gate) else $error("precharge began without feedback");

  property p_fb_pol;
    $past(i_nrst) |-> o_neg_feedback_state == ($past(q.ctrl[CTRL_FB_POL]) ~^ $past(fb_s));
  endproperty
  a_fb_pol: assert property (p_fb_pol) else $error("feedback polarity wrong");

  property p_pre_after_neg;
    $rose(o_pre_close) |-> o_neg_close && $past(q.st) == ST_DELAY;
  endproperty
  a_pre_after_neg: assert property (p_pre_after_neg) else $error("pre closed out of order");

  property p_settle_done;
    $fell(o_pre_close) && o_pos_close |-> o_precharge_done_flag;
  endproperty
  a_settle_done: assert property (p_settle_done) else $error("done flag missing");

  property p_precond;
    o_pre_close || o_pos_close |-> o_preconditions_met;
  endproperty
  a_precond: assert property (p_precond) else $error("contactor without preconditions");

  property p_bypass;
    q.ctrl[CTRL_BYPASS] |=> !o_pre_close && !o_pos_close;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass ignored");

  property p_timeout;
    fail && ign_s && precond_now && !q.ctrl[CTRL_BYPASS]
      |=> (q.st == ST_RETRY || (q.st == ST_FAULT && o_precharge_fault)) && !o_pre_close;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not handled");

  property p_retry_open;
    q.st == ST_RETRY |-> !o_pre_close && !o_pos_close && q.partial_seen;
  endproperty
  a_retry_open: assert property (p_retry_open) else $error("retry with contactors closed");

  property p_pdu_mirror;
    o_pdu_pre_close == o_pre_close && o_pdu_pos_close == o_pos_close
      && o_pdu_neg_close == o_neg_close;
  endproperty
  a_pdu_mirror: assert property (p_pdu_mirror) else $error("pdu outputs differ");

  property p_no_hv;
    o_no_hv_flag |-> $past(q.ctrl[CTRL_SRC_PACK]);
  endproperty
  a_no_hv: assert property (p_no_hv) else $error("no-hv flag outside pack mode");
endmodule
`default_nettype wire

// ==== shared/hvps_pkg.sv ====
/*
  Constants, register map, states and shared helpers of the HV contactor
  pre-charge sequencer.
  Assumes a 100 MHz system clock and voltages in one common 16-bit LSB unit.
*/
// How it works
// - Selector closes negative contactor at wake or only when ignition starts sequence.
// - With feedback required, pre-charge waits until feedback shows negative closed.
// - Polarity option inverts feedback reading; result shown as a status flag.
// - On ignition, confirm negative closed, wait control delay, then close pre-charge.
// - Track bus voltage rate while pre-charging; close positive once rate is low.
// - After positive closes, wait hold time, open pre-charge, set done flag.
// - Contactors only with no faults, insulation ok, interlock ok, no plug; flag shows it.
// - Bypass option disables own pre-charge control for an external controller.
// - Selector judges completion by pack voltage compare or by voltage rate.
// - Bus above partial threshold means started; not reached in time means fault.
// - Pack mode: full detect when above full threshold and within delta of pack.
// - Pack mode: no-HV flag while bus is below the no-detect threshold.
// - Rate threshold is an on/off hysteresis pair in V/s; flag while satisfied.
// - Separate flags for partial and full high-voltage detection.
// - Fault timeout starts at pre-charge close; expiry before completion is a fault.
// - Retry waits a minimum delay; after a failed retry a separate wait time.
// - Attempts capped; retry only if bus passed partial threshold.
// - Same contactor logic drives direct pins and distribution unit outputs.
package hvps_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int unsigned TICKS_PER_SEC = 1_000_000 / TICK_TIME_US;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PARTIAL_THR = 8'h04;
  localparam logic [7:0] ADDR_FULL_THR = 8'h08;
  localparam logic [7:0] ADDR_DELTA_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_NO_HV_THR = 8'h10;
  localparam logic [7:0] ADDR_RATE_ON = 8'h14;
  localparam logic [7:0] ADDR_RATE_OFF = 8'h18;
  localparam logic [7:0] ADDR_NEG_DELAY = 8'h1C;
  localparam logic [7:0] ADDR_SETTLE_HOLD = 8'h20;
  localparam logic [7:0] ADDR_FAULT_TIMEOUT = 8'h24;
  localparam logic [7:0] ADDR_RETRY_MIN = 8'h28;
  localparam logic [7:0] ADDR_RETRY_WAIT = 8'h2C;
  localparam logic [7:0] ADDR_MAX_ATTEMPTS = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;

  localparam int unsigned CTRL_NEG_MODE = 0;
  localparam int unsigned CTRL_FB_REQ = 1;
  localparam int unsigned CTRL_FB_POL = 2;
  localparam int unsigned CTRL_BYPASS = 3;
  localparam int unsigned CTRL_SRC_PACK = 4;
  localparam int unsigned STAT_STATE_LSB = 8;
  localparam int unsigned STAT_ATT_LSB = 12;

  localparam logic [4:0] RST_CTRL = 5'h03;
  localparam logic [15:0] RST_PARTIAL_THR = 16'h0032;
  localparam logic [15:0] RST_FULL_THR = 16'h00C8;
  localparam logic [15:0] RST_DELTA_LIMIT = 16'h000A;
  localparam logic [15:0] RST_NO_HV_THR = 16'h0014;
  localparam logic [15:0] RST_RATE_ON = 16'h0032;
  localparam logic [15:0] RST_RATE_OFF = 16'h0064;
  localparam logic [15:0] RST_NEG_DELAY = 16'h0064;
  localparam logic [15:0] RST_SETTLE_HOLD = 16'h0064;
  localparam logic [15:0] RST_FAULT_TIMEOUT = 16'h07D0;
  localparam logic [15:0] RST_RETRY_MIN = 16'h03E8;
  localparam logic [15:0] RST_RETRY_WAIT = 16'h1388;
  localparam logic [3:0] RST_MAX_ATTEMPTS = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_NEG_WAIT = 3'h1,
    ST_DELAY = 3'h3,
    ST_PRECHG = 3'h2,
    ST_SETTLE = 3'h6,
    ST_DONE = 3'h7,
    ST_RETRY = 3'h5,
    ST_FAULT = 3'h4
  } hvps_state_t;

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// ==== rtl/hvps_sync.sv ====
/*
  Two-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; no bus coherence between bits.
*/
`timescale 1ns/10ps
`default_nettype none
module hvps_sync
  import hvps_pkg::*;
#(
  parameter int unsigned W = 7
)(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hvps_sync_t;

  hvps_sync_t q;
  hvps_sync_t d;

  always_comb
  begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      q <= '0;
    else
      q <= d;
  end

  assign o_sync = q.s2;
endmodule
`default_nettype wire

// ==== rtl/hvps_rate_det.sv ====
/*
  Bus voltage rate detector with on/off hysteresis, in volts per second.
  Assumes i_tick pulses once per timing tick on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hvps_rate_det
  import hvps_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic [15:0] i_voltage,
  input wire logic [15:0] i_rate_on,
  input wire logic [15:0] i_rate_off,
  output logic o_rate_met
);
  typedef struct packed {
    logic [15:0] v_last;
    logic met;
  } hvps_rate_t;

  hvps_rate_t q;
  hvps_rate_t d;
  logic [31:0] rate;

  // Per-tick difference scaled to a full second
  always_comb
  begin
    d = q;
    rate = 32'(abs_diff(i_voltage, q.v_last)) * 32'(TICKS_PER_SEC);
    if (i_tick)
    begin
      d.v_last = i_voltage;
      if (rate < 32'(i_rate_on))
        d.met = 1'b1;
      else if (rate > 32'(i_rate_off))
        d.met = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      q <= '0;
    else
      q <= d;
  end

  assign o_rate_met = q.met;
endmodule
`default_nettype wire

// ==== testbench/hvps_far_side.sv ====
/*
  Far-side model: contactor aux feedback contact and inverter bus voltage.
  Assumes contactor drives are registered levels on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hvps_far_side (
  input wire logic i_sys_clk,
  input wire logic i_neg_close,
  input wire logic i_pre_close,
  input wire logic i_pos_close,
  input wire logic i_fb_stuck_open,
  input wire logic i_fb_slow,
  input wire logic [15:0] i_pack_voltage,
  input wire logic [15:0] i_stall_level,
  output logic o_neg_feedback_raw,
  output logic [15:0] o_bus_voltage
);
  logic [7:0] fb_cnt = 8'h00;
  logic [15:0] bus_v = 16'h0000;
  logic [15:0] target;
  // Pulled high while open; aux contact grounds it after its own bounce time
  assign o_neg_feedback_raw = (fb_cnt < (i_fb_slow ? 8'h28 : 8'h02)) | i_fb_stuck_open;
  // Stall level lets a scenario hold the bus short of the pack
  assign target = i_pos_close ? i_pack_voltage :
    i_pre_close ? ((i_stall_level < i_pack_voltage) ? i_stall_level : i_pack_voltage) : 16'h0000;
  assign o_bus_voltage = bus_v;
  always @(posedge i_sys_clk)
  begin
    if (!i_neg_close)
      fb_cnt <= 8'h00;
    else if (fb_cnt != 8'hFF)
      fb_cnt <= fb_cnt + 8'h01;
    // Resistor path ramps slowly; bus capacitance bleeds down slowly
    if (bus_v < target)
      bus_v <= i_pos_close ? target : bus_v + 16'h0001;
    else if (bus_v > target)
      bus_v <= bus_v - 16'h0001;
  end
endmodule
`default_nettype wire

// ==== testbench/hv_contactor_precharge_sequencer_bench.sv ====
/*
  Bench for the pre-charge sequencer: AHB-Lite register tasks and pin scenarios.
  Assumes hvps_far_side as far side and a 10-cycle timing tick.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
`define WT(c, n) for (int k = 0; k < n && !(c); k++) @(posedge sys_clk);
module hv_contactor_precharge_sequencer_bench;
  import hvps_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, wake = 1'b1, ign = 1'b0;
  logic inv_flt = 1'b0, ins_flt = 1'b0, ilk_ok = 1'b1, plug = 1'b0, stuck = 1'b0, slow = 1'b0;
  logic pre_d = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [15:0] stall = 16'hFFFF;
  wire logic [31:0] hrdata;
  wire logic [15:0] bus_v;
  wire logic hready, hresp, fb_raw, neg, pre, pos, pneg, ppre, ppos;
  wire logic pm, fbs, rate, nohv, part, full, done, flt;
  int n_errors = 0, num_checks = 0, rises = 0, gap = 0;
  int gaps [4];
  logic [31:0] rv [13] = '{{27'h0, RST_CTRL}, {16'h0, RST_PARTIAL_THR}, {16'h0, RST_FULL_THR},
    {16'h0, RST_DELTA_LIMIT}, {16'h0, RST_NO_HV_THR}, {16'h0, RST_RATE_ON},
    {16'h0, RST_RATE_OFF}, {16'h0, RST_NEG_DELAY}, {16'h0, RST_SETTLE_HOLD},
    {16'h0, RST_FAULT_TIMEOUT}, {16'h0, RST_RETRY_MIN}, {16'h0, RST_RETRY_WAIT},
    {28'h0, RST_MAX_ATTEMPTS}};

  hvps_sequencer #(.P_TICK_CYCLES(10)) uut (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_wake(wake), .i_ignition(ign), .i_neg_feedback_raw(fb_raw), .i_inverter_fault(inv_flt),
    .i_insulation_fault(ins_flt), .i_interlock_loop_ok(ilk_ok),
    .i_charge_plug_present(plug), .i_bus_voltage(bus_v), .i_pack_voltage(16'h012C),
    .o_neg_close(neg), .o_pre_close(pre), .o_pos_close(pos), .o_pdu_neg_close(pneg),
    .o_pdu_pre_close(ppre), .o_pdu_pos_close(ppos), .o_preconditions_met(pm),
    .o_neg_feedback_state(fbs), .o_rate_condition_met(rate), .o_no_hv_flag(nohv),
    .o_partial_hv_flag(part), .o_full_hv_flag(full), .o_precharge_done_flag(done),
    .o_precharge_fault(flt));

  hvps_far_side far (.i_sys_clk(sys_clk), .i_neg_close(neg), .i_pre_close(pre),
    .i_pos_close(pos), .i_fb_stuck_open(stuck), .i_fb_slow(slow), .i_pack_voltage(16'h012C),
    .i_stall_level(stall), .o_neg_feedback_raw(fb_raw), .o_bus_voltage(bus_v));

  always #5 sys_clk = ~sys_clk;

  // Cycles with negative closed and pre-charge open before each pre-charge close
  always @(posedge sys_clk)
  begin
    pre_d <= pre;
    gap <= (pre || !neg) ? 0 : gap + 1;
    if (!ign)
      rises <= 0;
    else if (pre && !pre_d)
    begin
      if (rises < 4)
        gaps[rises] <= gap;
      rises <= rises + 1;
    end
  end

  always @(negedge sys_clk)
    if (nrst)
      `CHK("pdu copies", {neg, pre, pos}, {pneg, ppre, ppos})

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (!hready) @(posedge sys_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (!hready) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] ex);
    ahb(1'b0, a, 32'h0);
    `CHK("register", ex, rd)
    `CHK("response", 1'b0, hresp)
  endtask

  // Long pause lets the bus bleed down before the next scenario
  task ign_off;
    ign <= 1'b0;
    repeat (400) @(posedge sys_clk);
  endtask

  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    summarize;
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 13; i++)
      rdc(8'(i * 4), rv[i]);
    ahb(1'b1, 8'h38, 32'hFFFF);
    rdc(8'h38, 32'h0);
    rdc(ADDR_CTRL, {27'h0, RST_CTRL});
    // Short timers keep the run brief
    ahb(1'b1, ADDR_NEG_DELAY, 32'h3);
    ahb(1'b1, ADDR_SETTLE_HOLD, 32'h4);
    ahb(1'b1, ADDR_FAULT_TIMEOUT, 32'h3C);
    ahb(1'b1, ADDR_RETRY_MIN, 32'h5);
    ahb(1'b1, ADDR_RETRY_WAIT, 32'h8);
    for (int i = 0; i < 4; i++)
    begin
      {inv_flt, ins_flt, ilk_ok, plug} <= 4'b0010 ^ (4'b1000 >> i);
      repeat (6) @(posedge sys_clk);
      `CHK("precond lost", 1'b0, pm)
      {inv_flt, ins_flt, ilk_ok, plug} <= 4'b0010;
      repeat (6) @(posedge sys_clk);
      `CHK("precond met", 1'b1, pm)
    end
    ign <= 1'b1;
    `WT(neg, 20)
    `CHK("neg on ignition", 1'b1, neg)
    `WT(pre, 100)
    `CHK("pre after delay", 1'b1, pre && gap >= 30)
    `WT(pos, 1000)
    `CHK("rate and partial", 3'h7, {pos, rate, part})
    `WT(done, 100)
    `CHK("done contactors", 4'hB, {neg, pre, pos, done})
    rdc(ADDR_STATUS, 32'h00000077 | (32'(ST_DONE) << STAT_STATE_LSB) | 32'h1000);
    ign_off;
    ahb(1'b1, ADDR_CTRL, 32'h13);
    slow <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("no hv", 1'b1, nohv)
    ign <= 1'b1;
    `WT(done, 1500)
    `CHK("pack full", 3'h3, {done, full})
    `CHK("no hv gone", 1'b0, nohv)
    ign_off;
    slow <= 1'b0;
    ahb(1'b1, ADDR_CTRL, 32'h03);
    stall <= 16'h0000;
    ign <= 1'b1;
    `WT(flt, 590)
    `CHK("early fault", 1'b0, flt)
    `WT(flt, 100)
    `CHK("timeout fault", 4'h8, {flt, pre, pos, part})
    repeat (200) @(posedge sys_clk);
    `CHK("no retry without voltage", 1, rises)
    ign_off;
    ahb(1'b1, ADDR_CTRL, 32'h13);
    stall <= 16'h0064;
    ign <= 1'b1;
    `WT(flt, 5000)
    `CHK("attempts capped", 35'h400000003, {flt, pre, pos, 32'(rises)})
    `CHK("retry min", 1'b1, gaps[1] >= 80 && gaps[1] < 100 && gaps[2] >= 110)
    ign_off;
    ahb(1'b1, ADDR_CTRL, 32'h03);
    stall <= 16'hFFFF;
    stuck <= 1'b1;
    ign <= 1'b1;
    repeat (200) @(posedge sys_clk);
    `CHK("feedback gate", 3'h4, {neg, pre, fbs})
    ign_off;
    stuck <= 1'b0;
    ahb(1'b1, ADDR_CTRL, 32'h00);
    repeat (20) @(posedge sys_clk);
    `CHK("wake close", 2'h3, {neg, fbs})
    ahb(1'b1, ADDR_CTRL, 32'h04);
    repeat (6) @(posedge sys_clk);
    `CHK("polarity", 1'b0, fbs)
    ahb(1'b1, ADDR_CTRL, 32'h0B);
    ign <= 1'b1;
    repeat (200) @(posedge sys_clk);
    `CHK("bypass", 2'h0, {pre, pos})
    summarize;
  end
endmodule
`default_nettype wire
